// ==== design/mpss_device.sv ====
// Module end: power-state sequencer driven by the host pins
module mpss_device
	import mpss_pkg::*;
#(
	parameter int unsigned TICK = TICK_CYCLES,
	parameter int unsigned ON_MS = POWER_ON_MS,
	parameter int unsigned OFF_MS = POWER_OFF_MS,
	parameter int unsigned DETACH_MS = ORDERLY_OFF_MS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Pins
	mpss_if.device pins,
	// Core side
	input wire logic shutdown_command,
	input wire logic fast_shutdown_command,
	input wire logic fast_enable,
	input wire logic sleep_request,
	input wire logic psm_enable,
	input wire logic update_timer_expired,
	input wire logic scheduled_wake,
	output logic baseband_on,
	output logic cmd_ready,
	output logic detach_request,
	output logic core_reset
);
	mpss_state_t state_reg, state_next;
	logic [2:0] key_sync, hard_sync, gpio_sync;
	logic key_low, hard_low, gpio_fall, key_released;
	logic tick;
	logic [MS_W-1:0] press_ms, state_ms;
	logic press_done_reg;
	logic [MS_W-1:0] duty_ms_reg;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers; pull-ups live in the interface wire
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			key_sync <= 3'h7;
			hard_sync <= 3'h7;
			gpio_sync <= 3'h7;
		end else begin
			key_sync <= {key_sync[1:0], pins.power_key_n};
			hard_sync <= {hard_sync[1:0], pins.hard_shutdown_n};
			gpio_sync <= {gpio_sync[1:0], pins.fast_gpio};
		end
	end
	assign key_low = ~key_sync[1];
	assign key_released = key_sync[1] & ~key_sync[2];
	assign hard_low = ~hard_sync[1];
	assign gpio_fall = ~gpio_sync[1] & gpio_sync[2];

	mpss_ms_timer #(.TICK(TICK)) u_press (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.active(key_low),
		.tick(tick),
		.ms_count(press_ms)
	);

	////////////////////////////////////////////////////////////////////
	// Armed one ms past threshold, as tick phase can lose one
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			press_done_reg <= 1'b0;
		else if (state_reg != state_next)
			press_done_reg <= 1'b0;
		else if (key_low && press_ms > MS_W'(ON_MS)
			&& (state_reg == ST_OFF || state_reg == ST_DEEP))
			press_done_reg <= 1'b1;
	end

	// Time spent in current state, in ms
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			state_ms <= '0;
		else if (state_reg != state_next)
			state_ms <= '0;
		else if (tick && state_ms != {MS_W{1'b1}})
			state_ms <= state_ms + 1'b1;
	end

	// Own wrapping phase: state_ms saturates and would stall the duty
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			duty_ms_reg <= '0;
		else if (state_reg != ST_SLEEP)
			duty_ms_reg <= '0;
		else if (tick && duty_ms_reg == MS_W'(SLEEP_PERIOD_MS - 1))
			duty_ms_reg <= '0;
		else if (tick)
			duty_ms_reg <= duty_ms_reg + 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: begin
				// Only exit is towards on, via reset sequence
				if (press_done_reg && key_released)
					state_next = ST_STARTUP;
			end
			ST_STARTUP: begin
				// Reset held internally by core_reset, host need not touch the hard line
				if (state_ms >= MS_W'(STARTUP_RESET_MS))
					state_next = ST_ON;
			end
			ST_ON, ST_SLEEP: begin
				if (hard_low)
					state_next = ST_HARD_RESET;
				else if (fast_enable && (gpio_fall || fast_shutdown_command))
					state_next = ST_FAST_OFF;
				else if (shutdown_command || (key_low
					&& press_ms > MS_W'(OFF_MS)))
					state_next = ST_DETACH;
				else if (psm_enable && update_timer_expired)
					state_next = ST_DEEP;
				else if (state_reg == ST_ON && sleep_request)
					state_next = ST_SLEEP;
				else if (state_reg == ST_SLEEP && !sleep_request)
					state_next = ST_ON;
			end
			ST_DETACH: begin
				// Filesystem close and detach take over a second
				if (hard_low)
					state_next = ST_HARD_RESET;
				else if (state_ms >= MS_W'(DETACH_MS))
					state_next = ST_OFF;
			end
			ST_DEEP: begin
				// Hard shutdown toggles have no effect here
				if (scheduled_wake || (press_done_reg && key_released))
					state_next = ST_STARTUP;
			end
			ST_HARD_RESET: begin
				if (!hard_low)
					state_next = ST_OFF;
			end
			ST_FAST_OFF: begin
				if (hard_low)
					state_next = ST_HARD_RESET;
				else if (state_ms >= MS_W'(FAST_OFF_MS))
					state_next = ST_OFF;
			end
			default: state_next = ST_OFF;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			state_reg <= ST_OFF;
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			baseband_on <= 1'b0;
			cmd_ready <= 1'b0;
			detach_request <= 1'b0;
			core_reset <= 1'b1;
			pins.power_monitor <= 1'b0;
			pins.aux_supply_out <= 1'b0;
		end else begin
			// Sleep duty-cycles the processor; commands wait for ST_ON
			baseband_on <= state_next == ST_ON || state_next == ST_DETACH
				|| (state_next == ST_SLEEP
				&& duty_ms_reg < MS_W'(SLEEP_AWAKE_MS));
			cmd_ready <= state_next == ST_ON;
			// Pulse once on entering orderly off, never on hard path
			detach_request <= state_next == ST_DETACH
				&& state_reg != ST_DETACH;
			core_reset <= state_next == ST_HARD_RESET
				|| state_next == ST_STARTUP || state_next == ST_OFF
				|| state_next == ST_DEEP;
			// Monitor drops only in off, deep sleep and hard reset, each with core_reset held
			pins.power_monitor <= state_next != ST_OFF
				&& state_next != ST_DEEP
				&& state_next != ST_HARD_RESET;
			pins.aux_supply_out <= state_next != ST_OFF
				&& state_next != ST_DEEP
				&& state_next != ST_HARD_RESET;
		end
	end
endmodule

// ==== design/mpss_host.sv ====
// Host end: drives timed presses on the open-drain control pins
module mpss_host
	import mpss_pkg::*;
#(
	parameter int unsigned TICK = TICK_CYCLES,
	parameter int unsigned ON_MS = POWER_ON_MS,
	parameter int unsigned OFF_MS = POWER_OFF_MS,
	parameter int unsigned HARD_MS = HARD_SHDN_MS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Pins
	mpss_if.host pins,
	// User requests, one-cycle pulses except the req_fast level, and the supply_good level
	input wire logic req_power_on,
	input wire logic req_power_off,
	input wire logic req_hard,
	input wire logic req_fast,
	input wire logic supply_good,
	// Status
	output logic busy,
	output logic module_on
);
	mpss_host_t st_reg;
	logic [1:0] mon_sync;
	logic [MS_W-1:0] target_reg, ms;
	logic tick;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			mon_sync <= 2'h0;
		else
			mon_sync <= {mon_sync[0], pins.power_monitor};
	end

	mpss_ms_timer #(.TICK(TICK)) u_hold (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.active(st_reg == H_PRESS || st_reg == H_HARD),
		.tick(tick),
		.ms_count(ms)
	);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= H_IDLE;
			target_reg <= '0;
			pins.power_key_oe <= 1'b0;
			pins.hard_shutdown_oe <= 1'b0;
			pins.fast_gpio <= 1'b1;
			busy <= 1'b0;
			module_on <= 1'b0;
		end else begin
			module_on <= mon_sync[1];
			pins.fast_gpio <= ~req_fast;
			case (st_reg)
				H_IDLE: begin
					busy <= 1'b0;
					if (req_hard) begin
						st_reg <= H_HARD;
						pins.hard_shutdown_oe <= 1'b1;
						busy <= 1'b1;
					end else if (req_power_on && supply_good) begin
						// Low supply: the power-on request is ignored
						st_reg <= H_PRESS;
						target_reg <= MS_W'(ON_MS + 1);
						pins.power_key_oe <= 1'b1;
						busy <= 1'b1;
					end else if (req_power_off) begin
						st_reg <= H_PRESS;
						target_reg <= MS_W'(OFF_MS + 1);
						pins.power_key_oe <= 1'b1;
						busy <= 1'b1;
					end
				end
				H_PRESS: begin
					// Two extra ms: module may miss a tick, wants one more
					if (ms > target_reg) begin
						pins.power_key_oe <= 1'b0;
						st_reg <= H_WAIT;
					end
				end
				H_HARD: begin
					if (ms > MS_W'(HARD_MS)) begin
						pins.hard_shutdown_oe <= 1'b0;
						st_reg <= H_WAIT;
					end
				end
				H_WAIT: st_reg <= H_IDLE;
				default: st_reg <= H_IDLE;
			endcase
		end
	end
endmodule

// ==== design/mpss_if.sv ====
// Interface: the pins between host and module; power key and hard shutdown are open drain
interface mpss_if;
	logic power_key_oe;
	logic hard_shutdown_oe;
	logic fast_gpio;
	logic power_monitor;
	logic aux_supply_out;
	// Open drain with internal pull-up: low only while someone drives
	logic power_key_n;
	logic hard_shutdown_n;
	assign power_key_n = ~power_key_oe;
	assign hard_shutdown_n = ~hard_shutdown_oe;
	modport device (
		input power_key_n,
		input hard_shutdown_n,
		input fast_gpio,
		output power_monitor,
		output aux_supply_out
	);
	modport host (
		output power_key_oe,
		output hard_shutdown_oe,
		output fast_gpio,
		input power_monitor
	);
endinterface

// ==== design/mpss_ms_timer.sv ====
// Millisecond tick and low-duration counter for a synchronised level
module mpss_ms_timer
	import mpss_pkg::*;
#(
	parameter int unsigned TICK = TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Measurement
	input wire logic active,
	output logic tick,
	output logic [MS_W-1:0] ms_count
);
	logic [31:0] div_reg;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			div_reg <= 32'h0;
			tick <= 1'b0;
		end else if (div_reg == TICK - 1) begin
			div_reg <= 32'h0;
			tick <= 1'b1;
		end else begin
			div_reg <= div_reg + 32'h1;
			tick <= 1'b0;
		end
	end

	// Saturates so a stuck line cannot wrap into a short press
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			ms_count <= '0;
		else if (!active)
			ms_count <= '0;
		else if (tick && ms_count != {MS_W{1'b1}})
			ms_count <= ms_count + 1'b1;
	end
endmodule

// ==== design/mpss_pkg.sv ====
// Package: constants and types shared by both ends of the power sequencer
package mpss_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	// Slow tick used for press measurement, one per millisecond
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	// Pin timings in milliseconds
	localparam int unsigned POWER_ON_MS = 5000;
	localparam int unsigned WAKE_MS = 5000;
	localparam int unsigned POWER_OFF_MS = 3000;
	localparam int unsigned HARD_SHDN_MS = 200;
	localparam int unsigned ORDERLY_OFF_MS = 1000;
	localparam int unsigned STARTUP_RESET_MS = 10;
	localparam int unsigned FAST_OFF_MS = 1;
	// Sleep duty cycle, in ticks
	localparam int unsigned SLEEP_PERIOD_MS = 100;
	localparam int unsigned SLEEP_AWAKE_MS = 10;
	localparam int unsigned MS_W = 16;

	typedef enum logic [7:0] {
		ST_OFF = 8'h01,
		ST_STARTUP = 8'h02,
		ST_ON = 8'h04,
		ST_SLEEP = 8'h08,
		ST_DETACH = 8'h10,
		ST_DEEP = 8'h20,
		ST_HARD_RESET = 8'h40,
		ST_FAST_OFF = 8'h80
	} mpss_state_t;

	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_PRESS = 4'h2,
		H_HARD = 4'h4,
		H_WAIT = 4'h8
	} mpss_host_t;
endpackage

// ==== test/module_power_state_sequencer_test.sv ====
// Testbench: both ends joined, host requests against module states
module module_power_state_sequencer_test
	import mpss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, reset_n, busy, module_on, baseband_on, cmd_ready;
	logic detach_request, core_reset, shutdown_command, fast_shutdown_command;
	logic fast_enable, sleep_request, psm_enable, update_timer_expired;
	logic scheduled_wake, req_power_on, req_power_off, req_hard, req_fast;
	logic supply_good;
	int err_total, n_checks, det_cnt, cyc, r, d0;
	// Row: op code, expected monitor, expected detach
	localparam logic [4:0] ROWS [10] = '{5'h02, 5'h05, 5'h02, 5'h09, 5'h02,
		5'h0C, 5'h02, 5'h10, 5'h02, 5'h14};
	mpss_if u_mpss_if();
	mpss_device #(.TICK(10), .ON_MS(8), .OFF_MS(3), .DETACH_MS(2)) u_mpss_device (
		.clk_sys, .reset_n, .pins(u_mpss_if), .shutdown_command,
		.fast_shutdown_command, .fast_enable, .sleep_request, .psm_enable,
		.update_timer_expired, .scheduled_wake, .baseband_on, .cmd_ready,
		.detach_request, .core_reset);
	mpss_host #(.TICK(10), .ON_MS(8), .OFF_MS(3), .HARD_MS(2)) u_mpss_host (
		.clk_sys, .reset_n, .pins(u_mpss_if), .req_power_on, .req_power_off,
		.req_hard, .req_fast, .supply_good, .busy, .module_on);
	mpss_monitor #(.TICK(10), .ON_MS(8), .OFF_MS(3), .DETACH_MS(2),
		.HARD_MS(2)) u_mpss_monitor (.clk_sys, .reset_n,
		.power_key_oe(u_mpss_if.power_key_oe),
		.hard_shutdown_oe(u_mpss_if.hard_shutdown_oe),
		.fast_gpio(u_mpss_if.fast_gpio),
		.power_monitor(u_mpss_if.power_monitor),
		.aux_supply_out(u_mpss_if.aux_supply_out),
		.power_key_n(u_mpss_if.power_key_n),
		.hard_shutdown_n(u_mpss_if.hard_shutdown_n));
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// One-cycle request; gpio level stays until the row ends
	task automatic do_op(input logic [2:0] op);
		@(negedge clk_sys);
		case (op)
			3'h0: req_power_on = 1'b1;
			3'h1: req_power_off = 1'b1;
			3'h2: shutdown_command = 1'b1;
			3'h3: req_hard = 1'b1;
			3'h4: req_fast = 1'b1;
			3'h5: fast_shutdown_command = 1'b1;
			3'h6: update_timer_expired = 1'b1;
			default: scheduled_wake = 1'b1;
		endcase
		@(negedge clk_sys);
		req_power_on = 1'b0;
		req_power_off = 1'b0;
		req_hard = 1'b0;
		shutdown_command = 1'b0;
		fast_shutdown_command = 1'b0;
		update_timer_expired = 1'b0;
		scheduled_wake = 1'b0;
	endtask
	task automatic settle(input logic exp);
		int i;
		for (i = 0; i < 600; i++) begin
			@(negedge clk_sys);
			if (busy === 1'b0 && u_mpss_if.power_monitor === exp) break;
		end
		// Long enough for the start-up reset to finish
		repeat ((STARTUP_RESET_MS + 2) * 10) @(negedge clk_sys);
		check(u_mpss_if.power_monitor, exp);
		check(u_mpss_if.aux_supply_out, exp);
		check(module_on, exp);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (detach_request === 1'b1) det_cnt++;
		cyc++;
		// Whole run needs about 5000 cycles
		if (cyc == 40000) begin
			err_total++;
			results();
		end
	end
	initial begin
		reset_n = 1'b0;
		shutdown_command = 1'b0;
		fast_shutdown_command = 1'b0;
		sleep_request = 1'b0;
		psm_enable = 1'b0;
		update_timer_expired = 1'b0;
		scheduled_wake = 1'b0;
		req_power_on = 1'b0;
		req_power_off = 1'b0;
		req_hard = 1'b0;
		req_fast = 1'b0;
		fast_enable = 1'b1;
		supply_good = 1'b1;
		repeat (16) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		check(u_mpss_if.power_monitor, 1'b0);
		check(core_reset, 1'b1);
		check(u_mpss_if.hard_shutdown_n, 1'b1);
		for (r = 0; r < 10; r++) begin
			d0 = det_cnt;
			do_op(ROWS[r][4:2]);
			settle(ROWS[r][1]);
			check(core_reset, !ROWS[r][1]);
			check(baseband_on, ROWS[r][1]);
			check(det_cnt - d0, ROWS[r][0]);
			req_fast = 1'b0;
		end
		do_op(3'h3);
		settle(1'b0);
		supply_good = 1'b0;
		do_op(3'h0);
		settle(1'b0);
		supply_good = 1'b1;
		do_op(3'h0);
		settle(1'b1);
		sleep_request = 1'b1;
		repeat (300) @(negedge clk_sys);
		check(u_mpss_if.power_monitor, 1'b1);
		check(cmd_ready, 1'b0);
		sleep_request = 1'b0;
		repeat (1100) @(negedge clk_sys);
		check(cmd_ready, 1'b1);
		// Deep sleep: hard press ignored, scheduled wake still returns
		psm_enable = 1'b1;
		do_op(3'h6);
		settle(1'b0);
		do_op(3'h3);
		do_op(3'h7);
		settle(1'b1);
		do_op(3'h6);
		settle(1'b0);
		do_op(3'h0);
		settle(1'b1);
		// Fast shutdown disabled: the command must be ignored
		fast_enable = 1'b0;
		do_op(3'h5);
		settle(1'b1);
		fast_enable = 1'b1;
		results();
	end
endmodule

// ==== test/mpss_monitor.sv ====
// Checker: pin timing relations between host and module ends
module mpss_monitor
	import mpss_pkg::*;
#(
	parameter int unsigned TICK = TICK_CYCLES,
	parameter int unsigned ON_MS = POWER_ON_MS,
	parameter int unsigned OFF_MS = POWER_OFF_MS,
	parameter int unsigned DETACH_MS = ORDERLY_OFF_MS,
	parameter int unsigned HARD_MS = HARD_SHDN_MS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Pins
	input wire logic power_key_oe,
	input wire logic hard_shutdown_oe,
	input wire logic fast_gpio,
	input wire logic power_monitor,
	input wire logic aux_supply_out,
	input wire logic power_key_n,
	input wire logic hard_shutdown_n
);
	localparam int ON_CYC = ON_MS * TICK;
	localparam int OFF_CYC = OFF_MS * TICK;
	localparam int MIN_OFF = (OFF_MS + DETACH_MS - 2) * TICK;
	localparam int HARD_CYC = HARD_MS * TICK;
	localparam int UP_WIN = (STARTUP_RESET_MS + 2) * TICK;
	localparam int DOWN_WIN = (DETACH_MS + 3) * TICK;
	localparam int FAST_WIN = (FAST_OFF_MS + 2) * TICK;
	logic [31:0] key_low_reg;
	logic [31:0] press_reg;
	logic [31:0] age_reg;
	logic [31:0] hard_low_reg;
	logic armed_reg;
	logic hard_hit_reg;
	////////////////////////////////////////////////////////////////////
	// Press length kept after release, since the answer comes late
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			key_low_reg <= '0;
			press_reg <= '0;
			age_reg <= '0;
		end else begin
			key_low_reg <= power_key_n ? '0 : key_low_reg + 32'h1;
			if (!power_key_n) press_reg <= key_low_reg + 32'h1;
			age_reg <= (!power_key_n && key_low_reg == 32'h0) ? 32'h1 :
				age_reg + 32'h1;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hard_low_reg <= '0;
			armed_reg <= 1'b0;
			hard_hit_reg <= 1'b0;
		end else begin
			hard_low_reg <= hard_shutdown_n ? '0 : hard_low_reg + 32'h1;
			// Armed only if the press began while the module was up
			hard_hit_reg <= !hard_shutdown_n && (hard_hit_reg
				|| (hard_low_reg == 32'h0 && power_monitor));
			armed_reg <= power_monitor && (armed_reg || key_low_reg == OFF_CYC);
		end
	end
	////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_on_needs_press: assert property (
		$rose(power_monitor) |-> press_reg >= ON_CYC)
		else $error("monitor rose without a long press");
	a_on_follows: assert property (
		$rose(power_key_n) && !power_monitor && press_reg >= ON_CYC
		|-> ##[1:UP_WIN] power_monitor) else $error("no start after press");
	a_off_press: assert property (
		power_monitor && key_low_reg == OFF_CYC |-> ##[1:DOWN_WIN] !power_monitor)
		else $error("off press did not power down");
	a_detach_lasts: assert property (
		$fell(power_monitor) && armed_reg |-> age_reg >= MIN_OFF)
		else $error("orderly off ended too soon");
	a_hard_off: assert property (
		$rose(hard_shutdown_n) && hard_hit_reg |-> !power_monitor [*8])
		else $error("no shutdown after hard release");
	a_hard_host: assert property (
		$rose(hard_shutdown_n) |-> hard_low_reg >= HARD_CYC)
		else $error("hard press too short");
	a_hard_pullup: assert property (
		!hard_shutdown_oe |-> hard_shutdown_n) else $error("hard line not pulled up");
	a_fast_off: assert property (
		$fell(fast_gpio) && power_monitor |-> ##[1:FAST_WIN] !power_monitor)
		else $error("fast gpio edge did not power down");
	c_power_up: cover property ($rose(power_monitor));
	c_orderly: cover property ($fell(power_monitor) && armed_reg);
	c_hard: cover property ($rose(hard_shutdown_n) && hard_hit_reg);
	c_aux: cover property (aux_supply_out && power_key_oe);
endmodule
